//--- hw/lcdid_decoder.sv
// Instruction decoder and reset logic of the display controller
// Summary of operation
// R1: Pin reset: display off, defaults, bias one-sixth.
// R2: Pin reset clears modes, addresses, level.
// R3: Reset byte clears modes, addresses, level.
// R4: During reset only status read accepted.
// R5: Status bit 4 shows reset in progress.
// R6: Host asserts reset pin before use.
// R7: Data transfers reach frame memory.
// R8: Status: busy, segment, display, reset, zeros.
// R9: Display on/off from bit 0.
// R10: Load six-bit start line.
// R11: Two-byte reference level sequence.
// R12: Load four-bit page address.
// R13: Column address high and low parts.
// R14: Segment direction from bit 0.
// R15: Inversion and all-pixels-on from bit 0.
// R16: Bias select from bit 0.
// R17: Enter and leave modify-read mode.
// R18: Common scan direction from bit 3.
// R19: Booster, regulator, follower enables.
// R20: Static indicator from bit 0.
// R21: Display off plus all-on is power save.
// R22: Host never issues test bytes.
// R23: Entry mode ends after second byte.
// R24: Busy rejects instructions.
// R25: Undefined bytes are ignored.
`timescale 1ns/10ps
module lcdid_decoder
    import lcdid_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic hw_init_pin_n,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic reg_select_line,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data,
    input wire logic [7:0] fm_rd_data,
    output logic fm_wr_stb,
    output logic fm_rd_stb,
    output logic [7:0] fm_wr_data,
    output logic display_on,
    output logic all_pixels_on_bit,
    output logic seg_reverse,
    output logic invert_bit,
    output logic bias_select,
    output logic booster_enable,
    output logic regulator_enable,
    output logic follower_enable,
    output logic modify_read,
    output logic com_scan_dir,
    output logic static_ind,
    output logic ref_entry,
    output logic [5:0] start_line_field,
    output logic [6:0] col_field,
    output logic [3:0] page_field,
    output logic [4:0] ref_level_field,
    output logic power_save,
    output logic busy
);
    // ************************************************************
    // Reset pin synchroniser and reset sequencing
    // ************************************************************
    logic [2:0] pin_sync_q;
    logic pin_low_q;
    logic [3:0] rst_cnt_q;
    logic [3:0] rst_cnt_d;
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pin_sync_q <= 3'h0;
            pin_low_q <= 1'b1;
        end
        else
        begin
            pin_sync_q <= {pin_sync_q[1:0], hw_init_pin_n};
            if (pin_sync_q[1] == pin_sync_q[2])
            begin
                pin_low_q <= ~pin_sync_q[2];
            end
        end
    end

    wire cmd_wr = wr_stb & ~reg_select_line;
    wire rst_busy = pin_low_q | (rst_cnt_q != 4'h0);
    wire accept = cmd_wr & ~rst_busy; // [R4] [R24]
    wire is_reset = accept & (wr_data == LCDID_OP_RESET);
    wire hard_rst = pin_low_q;

    assign rst_cnt_d = is_reset ? LCDID_RST_CYC : ((rst_cnt_q != 4'h0) ? rst_cnt_q - 4'h1 : 4'h0);
    always_ff @(posedge clk)
    begin
        if (srst | hard_rst)
        begin
            rst_cnt_q <= 4'h0;
        end
        else
        begin
            rst_cnt_q <= rst_cnt_d;
        end
    end
    assign busy = rst_busy;

    // ************************************************************
    // Instruction decode
    // ************************************************************
    wire m_disp = accept & ((wr_data & LCDID_MSK_7) == LCDID_OP_DISP_DISPLAY_STATE_FLAG);
    wire m_seg = accept & ((wr_data & LCDID_MSK_7) == LCDID_OP_SEG_DIR);
    wire m_allon = accept & ((wr_data & LCDID_MSK_7) == LCDID_OP_ALL_ON);
    wire m_bias = accept & ((wr_data & LCDID_MSK_7) == LCDID_OP_BIAS);
    wire m_inv = accept & ((wr_data & LCDID_MSK_7) == LCDID_OP_INVERT);
    wire m_stat = accept & ((wr_data & LCDID_MSK_7) == LCDID_OP_STATIC);
    wire m_refm = accept & (wr_data == LCDID_OP_REF_MODE);
    wire m_rmws = accept & (wr_data == LCDID_OP_RMW_SET);
    wire m_rmwc = accept & (wr_data == LCDID_OP_RMW_CLR);
    wire m_start = accept & ((wr_data & LCDID_MSK_2) == LCDID_OP_START);
    // Second byte only counts while in entry mode; otherwise 100xxxxx other than 8'h81 is undefined
    wire m_refv = accept & ref_entry & ~m_refm & ((wr_data & LCDID_MSK_3) == LCDID_OP_REF_VAL);
    wire m_page = accept & ((wr_data & LCDID_MSK_4) == LCDID_OP_PAGE);
    wire m_com = accept & ((wr_data & LCDID_MSK_4) == LCDID_OP_COM_DIR);
    wire m_coll = accept & ((wr_data & LCDID_MSK_4) == LCDID_OP_COL_LO);
    wire m_colh = accept & ((wr_data & LCDID_MSK_5) == LCDID_OP_COL_HI);
    wire m_pwr = accept & ((wr_data & LCDID_MSK_5) == LCDID_OP_POWER);
    // Any defined code; everything else falls through untouched
    wire m_known = m_disp | m_seg | m_allon | m_bias | m_inv | m_stat | m_refm | m_rmws | m_rmwc | m_start
        | m_refv | m_page | m_com | m_coll | m_colh | m_pwr | is_reset;
    wire m_undef = accept & ~m_known; // [R25]

    // ************************************************************
    // Control state
    // ************************************************************
    always_ff @(posedge clk)
    begin
        if (srst | hard_rst) // [R1]
        begin
            display_on <= 1'b0;
            all_pixels_on_bit <= 1'b0;
            seg_reverse <= 1'b0;
            invert_bit <= 1'b0;
            {booster_enable, regulator_enable, follower_enable} <= LCDID_RST_PWR;
            bias_select <= LCDID_RST_BIAS;
        end
        else
        begin
            if (m_disp) display_on <= wr_data[0]; // [R9]
            if (m_allon) all_pixels_on_bit <= wr_data[0]; // [R15]
            if (m_inv) invert_bit <= wr_data[0]; // [R15]
            if (m_seg) seg_reverse <= wr_data[0]; // [R14]
            if (m_bias) bias_select <= wr_data[0]; // [R16]
            if (m_pwr) {booster_enable, regulator_enable, follower_enable} <= wr_data[2:0]; // [R19]
        end
    end

    // Shared by pin reset and reset instruction
    wire soft_clr = srst | hard_rst | is_reset; // [R2] [R3]
    always_ff @(posedge clk)
    begin
        if (soft_clr)
        begin
            modify_read <= 1'b0;
            com_scan_dir <= 1'b0;
            static_ind <= 1'b0;
            ref_entry <= 1'b0;
            start_line_field <= LCDID_RST_START;
            col_field <= LCDID_RST_COL;
            page_field <= LCDID_RST_PAGE;
            ref_level_field <= LCDID_RST_REF;
        end
        else
        begin
            if (m_rmws) modify_read <= 1'b1; // [R17]
            else if (m_rmwc) modify_read <= 1'b0; // [R17]
            if (m_com) com_scan_dir <= wr_data[3]; // [R18]
            if (m_stat) static_ind <= wr_data[0]; // [R20]
            if (m_refm) ref_entry <= 1'b1; // [R11]
            else if (m_refv) ref_entry <= 1'b0; // [R23]
            if (m_refv) ref_level_field <= wr_data[4:0]; // [R11]
            if (m_start) start_line_field <= wr_data[5:0]; // [R10]
            if (m_page) page_field <= wr_data[3:0]; // [R12]
            if (m_colh) col_field[6:4] <= wr_data[2:0]; // [R13]
            else if (m_coll) col_field[3:0] <= wr_data[3:0]; // [R13]
        end
    end

    assign power_save = ~display_on & all_pixels_on_bit; // [R21]

    // ************************************************************
    // Frame memory path and status read
    // ************************************************************
    wire data_ok = reg_select_line & ~rst_busy;
    wire data_wr = wr_stb & data_ok;
    logic fm_wr_stb_q;
    logic [7:0] fm_wr_data_q;
    // Write strobe and byte leave together from flops so the memory sees them aligned
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            fm_wr_stb_q <= 1'b0;
            fm_wr_data_q <= 8'h00;
        end
        else
        begin
            fm_wr_stb_q <= data_wr; // [R7]
            fm_wr_data_q <= wr_data;
        end
    end
    assign fm_wr_stb = fm_wr_stb_q;
    assign fm_wr_data = fm_wr_data_q;
    assign fm_rd_stb = rd_stb & data_ok; // [R7]

    logic [7:0] status_byte;
    always_comb
    begin
        status_byte = 8'h00;
        status_byte[LCDID_STAT_BUSY] = rst_busy; // [R8]
        status_byte[LCDID_STAT_SEG] = seg_reverse;
        status_byte[LCDID_STAT_DISP] = display_on;
        status_byte[LCDID_STAT_RST] = rst_busy; // [R5]
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rd_data <= 8'h00;
        end
        else if (rd_stb)
        begin
            rd_data <= reg_select_line ? (rst_busy ? 8'h00 : fm_rd_data) : status_byte;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    chk_pin_reset_state: assert property (@(posedge clk) disable iff (srst) // [R1]
        hard_rst |=> (!display_on && !all_pixels_on_bit && !seg_reverse && !invert_bit && !bias_select
                      && !booster_enable && !regulator_enable && !follower_enable))
        else $error("pin reset state wrong");
    chk_pin_reset_addr: assert property (@(posedge clk) disable iff (srst) // [R2]
        hard_rst |=> (col_field == 7'h00 && page_field == 4'h0 && ref_level_field == 5'h00 && !ref_entry))
        else $error("pin reset addresses wrong");
    chk_instr_reset: assert property (@(posedge clk) disable iff (srst) // [R3]
        is_reset |=> (start_line_field == 6'h00 && !modify_read && !static_ind && !com_scan_dir) ##1 busy [*8])
        else $error("reset instruction wrong");
    chk_busy_reject: assert property (@(posedge clk) disable iff (srst) // [R4]
        (busy && cmd_wr) |=> $stable(display_on) && $stable(page_field) && $stable(col_field))
        else $error("instruction accepted while busy");
    chk_status_bits: assert property (@(posedge clk) disable iff (srst) // [R8]
        (rd_stb && !reg_select_line) |=> (rd_data[3:0] == 4'h0 && rd_data[4] == $past(busy)
                                         && rd_data[6] == $past(seg_reverse)))
        else $error("status byte wrong");
    chk_display_set: assert property (@(posedge clk) disable iff (srst) // [R9]
        m_disp |=> display_on == $past(wr_data[0]))
        else $error("display on/off not applied");
    chk_ref_seq: assert property (@(posedge clk) disable iff (srst) // [R23]
        m_refv |=> (!ref_entry && ref_level_field == $past(wr_data[4:0])))
        else $error("reference level sequence wrong");
    chk_col_high: assert property (@(posedge clk) disable iff (srst) // [R13]
        m_colh |=> col_field[6:4] == $past(wr_data[2:0]))
        else $error("column high not loaded");
    chk_power_save: assert property (@(posedge clk) disable iff (srst) // [R21]
        (m_allon && !display_on) |=> power_save == $past(wr_data[0]))
        else $error("power save not entered with all pixels on");
    chk_power_leave: assert property (@(posedge clk) disable iff (srst) // [R21]
        (m_disp && all_pixels_on_bit) |=> power_save == !$past(wr_data[0]))
        else $error("power save not left with display on");
    chk_undefined: assert property (@(posedge clk) disable iff (srst) // [R25]
        m_undef |=> $stable({display_on, all_pixels_on_bit, seg_reverse, invert_bit, bias_select, booster_enable,
                             regulator_enable, follower_enable, modify_read, com_scan_dir, static_ind, ref_entry,
                             start_line_field, col_field, page_field, ref_level_field}))
        else $error("undefined byte changed state");

    // ************************************************************
    // Checks on field loads, counting and data path
    // ************************************************************
    chk_start_load: assert property (@(posedge clk) disable iff (srst) // [R10]
        m_start |=> start_line_field == $past(wr_data[5:0]))
        else $error("start line not loaded");
    chk_page_load: assert property (@(posedge clk) disable iff (srst) // [R12]
        m_page |=> page_field == $past(wr_data[3:0]))
        else $error("page address not loaded");
    chk_col_low: assert property (@(posedge clk) disable iff (srst) // [R13]
        m_coll |=> col_field[3:0] == $past(wr_data[3:0]))
        else $error("column low not loaded");
    chk_seg_dir: assert property (@(posedge clk) disable iff (srst) // [R14]
        m_seg |=> seg_reverse == $past(wr_data[0]))
        else $error("segment direction not loaded");
    chk_invert_set: assert property (@(posedge clk) disable iff (srst) // [R15]
        m_inv |=> invert_bit == $past(wr_data[0]))
        else $error("inversion not loaded");
    chk_all_on_set: assert property (@(posedge clk) disable iff (srst) // [R15]
        m_allon |=> all_pixels_on_bit == $past(wr_data[0]))
        else $error("all pixels on not loaded");
    chk_bias_set: assert property (@(posedge clk) disable iff (srst) // [R16]
        m_bias |=> bias_select == $past(wr_data[0]))
        else $error("bias select not loaded");
    chk_rmw_enter: assert property (@(posedge clk) disable iff (srst) // [R17]
        m_rmws |=> modify_read)
        else $error("modify-read not entered");
    chk_rmw_leave: assert property (@(posedge clk) disable iff (srst) // [R17]
        m_rmwc |=> !modify_read)
        else $error("modify-read not left");
    chk_com_dir: assert property (@(posedge clk) disable iff (srst) // [R18]
        m_com |=> com_scan_dir == $past(wr_data[3]))
        else $error("common direction not loaded");
    chk_power_enables: assert property (@(posedge clk) disable iff (srst) // [R19]
        m_pwr |=> {booster_enable, regulator_enable, follower_enable} == $past(wr_data[2:0]))
        else $error("power enables not loaded");
    chk_static_set: assert property (@(posedge clk) disable iff (srst) // [R20]
        m_stat |=> static_ind == $past(wr_data[0]))
        else $error("static indicator not loaded");
    chk_ref_entry: assert property (@(posedge clk) disable iff (srst) // [R11]
        m_refm |=> ref_entry)
        else $error("reference entry mode not entered");
    chk_reset_load: assert property (@(posedge clk) disable iff (srst) // [R3]
        is_reset |=> rst_cnt_q == LCDID_RST_CYC)
        else $error("reset counter not loaded");
    chk_reset_count: assert property (@(posedge clk) disable iff (srst) // [R5]
        (rst_cnt_q != 4'h0 && !hard_rst) |=> rst_cnt_q == $past(rst_cnt_q) - 4'h1)
        else $error("reset counter not counting down");
    chk_status_top: assert property (@(posedge clk) disable iff (srst) // [R8]
        (rd_stb && !reg_select_line) |=> (rd_data[7] == $past(busy) && rd_data[5] == $past(display_on)))
        else $error("status busy or display bit wrong");
    chk_data_write: assert property (@(posedge clk) disable iff (srst) // [R7]
        (wr_stb && reg_select_line && !busy) |=> (fm_wr_stb && fm_wr_data == $past(wr_data)))
        else $error("data write not passed to memory");
    chk_data_read: assert property (@(posedge clk) disable iff (srst) // [R7]
        (rd_stb && reg_select_line && !busy) |=> rd_data == $past(fm_rd_data))
        else $error("data read not returned");
    chk_data_busy: assert property (@(posedge clk) disable iff (srst) // [R4]
        (wr_stb && busy) |=> !fm_wr_stb)
        else $error("data write passed while busy");
    chk_read_busy: assert property (@(posedge clk) disable iff (srst) // [R4]
        (rd_stb && reg_select_line && busy) |=> rd_data == 8'h00)
        else $error("data read answered while busy");

    // ************************************************************
    // Cover points
    // ************************************************************
    cov_ref_seq: cover property (@(posedge clk) m_refm ##[1:20] m_refv);
    cov_reset: cover property (@(posedge clk) is_reset ##[1:20] !busy);
    cov_data_wr: cover property (@(posedge clk) fm_wr_stb);
    cov_pin_reset: cover property (@(posedge clk) hard_rst ##1 !hard_rst);
    cov_power_save: cover property (@(posedge clk) m_allon ##1 power_save);
endmodule : lcdid_decoder

//--- hw/lcdid_pkg.sv
// Package of codes, field positions, reset values and timing counts for the instruction decoder
package lcdid_pkg;
    localparam logic [7:0] LCDID_OP_DISP_DISPLAY_STATE_FLAG = 8'hAE;
    localparam logic [7:0] LCDID_MSK_7 = 8'hFE;
    localparam logic [7:0] LCDID_OP_SEG_DIR = 8'hA0;
    localparam logic [7:0] LCDID_OP_ALL_ON = 8'hA4;
    localparam logic [7:0] LCDID_OP_BIAS = 8'hA2;
    localparam logic [7:0] LCDID_OP_INVERT = 8'hA6;
    localparam logic [7:0] LCDID_OP_STATIC = 8'hAC;
    localparam logic [7:0] LCDID_OP_REF_MODE = 8'h81;
    localparam logic [7:0] LCDID_OP_RMW_SET = 8'hE0;
    localparam logic [7:0] LCDID_OP_RMW_CLR = 8'hEE;
    localparam logic [7:0] LCDID_OP_RESET = 8'hE2;
    localparam logic [7:0] LCDID_MSK_2 = 8'hC0;
    localparam logic [7:0] LCDID_OP_START = 8'h40;
    localparam logic [7:0] LCDID_MSK_3 = 8'hE0;
    localparam logic [7:0] LCDID_OP_REF_VAL = 8'h80;
    localparam logic [7:0] LCDID_MSK_4 = 8'hF0;
    localparam logic [7:0] LCDID_OP_PAGE = 8'hB0;
    localparam logic [7:0] LCDID_OP_COM_DIR = 8'hC0;
    localparam logic [7:0] LCDID_OP_COL_LO = 8'h00;
    localparam logic [7:0] LCDID_OP_TEST = 8'hF0;
    localparam logic [7:0] LCDID_MSK_5 = 8'hF8;
    localparam logic [7:0] LCDID_OP_COL_HI = 8'h10;
    localparam logic [7:0] LCDID_OP_POWER = 8'h28;
    localparam int LCDID_STAT_BUSY = 7;
    localparam int LCDID_STAT_SEG = 6;
    localparam int LCDID_STAT_DISP = 5;
    localparam int LCDID_STAT_RST = 4;
    localparam logic LCDID_RST_BIAS = 1'b0;
    localparam logic [5:0] LCDID_RST_START = 6'h00;
    localparam logic [6:0] LCDID_RST_COL = 7'h00;
    localparam logic [3:0] LCDID_RST_PAGE = 4'h0;
    localparam logic [4:0] LCDID_RST_REF = 5'h00;
    localparam logic [2:0] LCDID_RST_PWR = 3'h0;
    localparam int LCDID_RST_INSTR_NS = 1000;
    localparam int LCDID_CLK_NS = 100;
    localparam logic [3:0] LCDID_RST_CYC = 4'((LCDID_RST_INSTR_NS + LCDID_CLK_NS - 1) / LCDID_CLK_NS);
endpackage : lcdid_pkg

//--- sim/lcdid_fm_model.sv
// Frame-memory stand-in that keeps the last data byte and returns it on reads
`timescale 1ns/10ps
module lcdid_fm_model
(
    input wire logic clk,
    input wire logic fm_wr_stb,
    input wire logic fm_rd_stb,
    input wire logic [7:0] fm_wr_data,
    output logic [7:0] fm_rd_data
);
    logic [7:0] mem_q;
    always_ff @(posedge clk)
    begin
        if (fm_wr_stb)
        begin
            mem_q <= fm_wr_data;
        end
    end
    // Unselected memory shows the inverse so a stale byte never passes for a read
    assign fm_rd_data = fm_rd_stb ? mem_q : ~mem_q;
endmodule : lcdid_fm_model

//--- sim/testbench.sv
// Self-checking bench for the instruction decoder and its reset paths
`timescale 1ns/10ps
module testbench
    import lcdid_pkg::*;
;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic hw_init_pin_n = 1'b0;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic reg_select_line = 1'b0;
    logic [7:0] wr_data = 8'h00;
    logic [7:0] rd_data, fm_rd_data, fm_wr_data;
    logic fm_wr_stb, fm_rd_stb, display_on, all_pixels_on_bit, seg_reverse, invert_bit, bias_select;
    logic booster_enable, regulator_enable, follower_enable, modify_read, com_scan_dir, static_ind, ref_entry;
    logic power_save, busy;
    logic [5:0] start_line_field;
    logic [6:0] col_field;
    logic [3:0] page_field;
    logic [4:0] ref_level_field;
    logic [33:0] ctl, snap;
    int errors = 0;
    int n_checks = 0;
    int cyc = 0;
    assign ctl = {display_on, all_pixels_on_bit, seg_reverse, invert_bit, bias_select, booster_enable,
        regulator_enable, follower_enable, modify_read, com_scan_dir, static_ind, ref_entry,
        start_line_field, col_field, page_field, ref_level_field};
    always #50 clk = ~clk;
    lcdid_decoder dut (.clk(clk), .srst(srst), .hw_init_pin_n(hw_init_pin_n), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .reg_select_line(reg_select_line), .wr_data(wr_data), .rd_data(rd_data), .fm_rd_data(fm_rd_data),
        .fm_wr_stb(fm_wr_stb), .fm_rd_stb(fm_rd_stb), .fm_wr_data(fm_wr_data), .display_on(display_on),
        .all_pixels_on_bit(all_pixels_on_bit), .seg_reverse(seg_reverse), .invert_bit(invert_bit),
        .bias_select(bias_select), .booster_enable(booster_enable), .regulator_enable(regulator_enable),
        .follower_enable(follower_enable), .modify_read(modify_read), .com_scan_dir(com_scan_dir),
        .static_ind(static_ind), .ref_entry(ref_entry), .start_line_field(start_line_field),
        .col_field(col_field), .page_field(page_field), .ref_level_field(ref_level_field),
        .power_save(power_save), .busy(busy));
    lcdid_fm_model fm (.clk(clk), .fm_wr_stb(fm_wr_stb), .fm_rd_stb(fm_rd_stb), .fm_wr_data(fm_wr_data),
        .fm_rd_data(fm_rd_data));
    task automatic finish_test();
        if (errors == 0 && n_checks > 0)
        begin
            $display("Test passed");
        end
        else
        begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
        n_checks++;
        if (g !== e)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic xfer(input logic rs, input logic wr, input logic [7:0] d);
        @(posedge clk);
        reg_select_line <= rs;
        wr_stb <= wr;
        rd_stb <= !wr;
        wr_data <= d;
        @(posedge clk);
        wr_stb <= 1'b0;
        rd_stb <= 1'b0;
        #1;
    endtask : xfer
    task automatic wr(input logic [7:0] d);
        xfer(1'b0, 1'b1, d);
    endtask : wr
    task automatic rd(input logic rs, input logic [7:0] e, input string n);
        xfer(rs, 1'b0, 8'h00);
        chk(n, 34'(e), 34'(rd_data));
    endtask : rd
    task automatic wait_idle();
        int i = 0;
        while (busy !== 1'b0 && i < 100)
        begin
            @(posedge clk);
            #1;
            i++;
        end
        chk("busy", 34'h0, 34'(busy));
    endtask : wait_idle
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            errors++;
            $display("[ERR] cycle limit expected 0 seen %0d", cyc);
            finish_test();
        end
    end
    // ******************************************
    // Main sequence
    // ******************************************
    initial
    begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        hw_init_pin_n <= 1'b1;
        wait_idle();
        rd(1'b0, 8'h00, "status idle");
        wr(8'hAF);
        chk("display_on", 34'h1, 34'(display_on));
        wr(8'hA1);
        chk("seg_reverse", 34'h1, 34'(seg_reverse));
        wr(8'hA7);
        wr(8'hA5);
        chk("invert and all on", 34'h3, 34'({invert_bit, all_pixels_on_bit}));
        wr(8'hA3);
        chk("bias_select", 34'h1, 34'(bias_select));
        wr(8'hAD);
        chk("static_ind", 34'h1, 34'(static_ind));
        wr(8'hE0);
        chk("modify_read set", 34'h1, 34'(modify_read));
        wr(8'hEE);
        chk("modify_read clr", 34'h0, 34'(modify_read));
        wr(8'hE0);
        wr(8'hCF);
        chk("com_scan_dir", 34'h1, 34'(com_scan_dir));
        wr(8'h2A);
        chk("power 010", 34'h2, 34'({booster_enable, regulator_enable, follower_enable}));
        wr(8'h2D);
        chk("power 101", 34'h5, 34'({booster_enable, regulator_enable, follower_enable}));
        wr(8'h7F);
        chk("start_line_field", 34'h3F, 34'(start_line_field));
        wr(8'hB8);
        chk("page_field", 34'h8, 34'(page_field));
        wr(8'h15);
        wr(8'h0A);
        chk("col_field", 34'h5A, 34'(col_field));
        wr(8'h80);
        chk("lone level byte", 34'h0, 34'(ref_level_field));
        wr(8'h81);
        chk("ref_entry", 34'h1, 34'(ref_entry));
        wr(8'h93);
        chk("level and entry", 34'h13, 34'({ref_entry, ref_level_field}));
        wr(8'h9F);
        chk("level after exit", 34'h13, 34'(ref_level_field));
        rd(1'b0, 8'h60, "status on");
        snap = ctl;
        wr(8'h18);
        wr(8'h20);
        wr(8'hA8);
        chk("undefined bytes", snap, ctl);
        wr(8'hAE);
        chk("power_save on", 34'h1, 34'(power_save));
        wr(8'hA4);
        chk("power_save off", 34'h0, 34'(power_save));
        wr(8'hAF);
        xfer(1'b1, 1'b1, 8'hC3);
        rd(1'b1, 8'hC3, "data read");
        snap = ctl;
        wr(LCDID_OP_RESET);
        rd(1'b0, 8'hF0, "status busy");
        wr(8'hAE);
        wait_idle();
        chk("reset instr", snap & 34'h3FC000000, ctl);
        rd(1'b0, 8'h60, "status done");
        @(posedge clk);
        hw_init_pin_n <= 1'b0;
        repeat (5) @(posedge clk);
        rd(1'b0, 8'h90, "status pin low");
        wr(8'hAF);
        chk("pin low state", 34'h0, ctl);
        xfer(1'b1, 1'b1, 8'h5A);
        rd(1'b1, 8'h00, "data read busy");
        @(posedge clk);
        hw_init_pin_n <= 1'b1;
        wait_idle();
        chk("pin released", 34'h0, ctl);
        rd(1'b1, 8'hC3, "data kept");
        finish_test();
    end
endmodule : testbench
